/* File: logic/ossd_dev.sv */
// Purpose: two open-drain stage controllers with diagnostics, SPI slave
// Assumes: all pins and comparator inputs asynchronous to i_ref_clk
// Notes:   faults are sticky until a clear or soft reset command
`timescale 1ns/100ps
module ossd_dev
  import ossd_pkg::*;
#(
  parameter logic [ossd_pkg::ADDR_W-1:0] DEV_ADDR = 2'h0,
  parameter int BLANK_N = ossd_pkg::BLANK_CYC,
  parameter int FILT_N  = ossd_pkg::FILT_CYC
) (
  // clock and chip reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_arst_n,
  // stage inputs, high = stage off
  input  wire logic [ossd_pkg::NSTAGE-1:0] i_stage_input,
  // analog comparators per stage
  input  wire logic [ossd_pkg::NSTAGE-1:0] i_scb_cmp,
  input  wire logic [ossd_pkg::NSTAGE-1:0] i_scg_cmp,
  input  wire logic [ossd_pkg::NSTAGE-1:0] i_ol_cmp,
  // stage drive and diagnostic current
  output logic [ossd_pkg::NSTAGE-1:0]      o_stage_output,
  output logic [ossd_pkg::NSTAGE-1:0]      o_diag_cur_en,
  // fault flags and enable state
  output logic [ossd_pkg::NSTAGE-1:0]      o_battery_short_fault,
  output logic [ossd_pkg::NSTAGE-1:0]      o_ground_short_fault,
  output logic [ossd_pkg::NSTAGE-1:0]      o_open_load_fault,
  output logic                             o_stages_enabled,
  // serial link
  ossd_if.dev                              spi
);
  import ossd_pkg::*;

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  if (BLANK_N < 1 || FILT_N < 1) begin : g_bad_par
    $error("ossd_dev: blanking and filter counts must be at least 1");
  end

  localparam int BW  = $clog2(BLANK_N + 1);
  localparam int FW  = $clog2(FILT_N + 1);
  localparam int SYW = 4 * NSTAGE + 3;
  localparam logic [BW-1:0] BLANK_END = BW'(BLANK_N);
  localparam logic [FW-1:0] FILT_END  = FW'(FILT_N - 1);
  // stage inputs and select idle high, the rest low
  localparam logic [SYW-1:0] SY_RST = {{NSTAGE{1'b1}},
                                       {(3 * NSTAGE){1'b0}}, 3'b010};

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [SYW-1:0]    raw;
  logic [SYW-1:0]    sy1_q;
  logic [SYW-1:0]    sy2_q;
  logic [NSTAGE-1:0] in_s, scb_s, scg_s, ol_s;
  logic              sck_s, ss_n_s, mosi_s;

  assign raw = {i_stage_input, i_scb_cmp, i_scg_cmp, i_ol_cmp,
                spi.sck, spi.ss_n, spi.mosi};

  // reset to idle levels so a floating input reads as off
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sy1_q <= SY_RST;
      sy2_q <= SY_RST;
    end else begin
      sy1_q <= raw;
      sy2_q <= sy1_q;
    end
  end

  assign {in_s, scb_s, scg_s, ol_s, sck_s, ss_n_s, mosi_s} = sy2_q;

  // ---------------------------------------------------------------
  // link edge detection
  // ---------------------------------------------------------------
  logic sck_d_q;
  logic ss_n_d_q;
  logic sck_rise, sck_fall, ss_fall, ss_rise;

  // the device never makes a clock, it only follows the host's
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sck_d_q  <= 1'b0;
      ss_n_d_q <= 1'b1;
    end else begin
      sck_d_q  <= sck_s;
      ss_n_d_q <= ss_n_s;
    end
  end

  assign sck_rise = sck_s & ~sck_d_q;
  assign sck_fall = ~sck_s & sck_d_q;
  assign ss_fall  = ~ss_n_s & ss_n_d_q;
  assign ss_rise  = ss_n_s & ~ss_n_d_q;

  // ---------------------------------------------------------------
  // frame engine, mode 0: sample on rise, shift out on fall
  // ---------------------------------------------------------------
  typedef enum logic {OSSD_IDLE, OSSD_SHIFT} ossd_dst_e;
  ossd_dst_e             st_q;
  logic [4:0]            cnt_q;
  logic [FRAME_BITS-1:0] rx_q;
  logic [FRAME_BITS-1:0] tx_q;
  logic                  addr_ok_q;
  logic                  frame_ok;
  logic [CMD_W-1:0]      cmd;
  logic [FRAME_BITS-1:0] status;
  logic                  enabled_q;
  logic [NSTAGE-1:0]     ol_dis_q;
  logic [NSTAGE*NFLT-1:0] flag_q;
  logic [NSTAGE*NFLT-1:0] flag_vis;

  // state follows the select line
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= OSSD_IDLE;
    end else begin
      case (st_q)
        OSSD_IDLE:  if (ss_fall) st_q <= OSSD_SHIFT;
        OSSD_SHIFT: if (ss_rise) st_q <= OSSD_IDLE;
        default:    st_q <= OSSD_IDLE;
      endcase
    end
  end

  // bit counter stops one past a full frame, so a long frame is refused
  // at select release instead of aliasing to sixteen
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 5'h00;
    end else if (ss_fall) begin
      cnt_q <= 5'h00;
    end else if (st_q == OSSD_SHIFT && sck_rise
                 && cnt_q <= FRAME_LAST + 5'h01) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // receive shift register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_q <= '0;
    end else if (st_q == OSSD_SHIFT && sck_rise) begin
      rx_q <= {rx_q[FRAME_BITS-2:0], mosi_s};
    end
  end

  // address latched after the second bit, only own frames act
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_ok_q <= 1'b0;
    end else if (ss_fall || st_q == OSSD_IDLE) begin
      addr_ok_q <= 1'b0;
    end else if (sck_rise && cnt_q == 5'(ADDR_W - 1)) begin
      addr_ok_q <= ({rx_q[ADDR_W-2:0], mosi_s} == DEV_ADDR);
    end
  end

  // status snapshot taken at select fall, bits above address slot zero
  always_comb begin
    status = '0;
    status[ST_EN_BIT] = enabled_q;
    status[ST_OLD_LSB +: NSTAGE] = ol_dis_q;
    status[ST_FLT_LSB +: NSTAGE*NFLT] = flag_vis;
  end

  // transmit shift register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tx_q <= '0;
    end else if (ss_fall) begin
      tx_q <= status;
    end else if (st_q == OSSD_SHIFT && sck_fall) begin
      tx_q <= {tx_q[FRAME_BITS-2:0], 1'b0};
    end
  end

  // driven only while selected and addressed; idle in reset
  assign spi.miso    = tx_q[FRAME_BITS-1];
  assign spi.miso_oe = (st_q == OSSD_SHIFT) & addr_ok_q & ~ss_n_s;

  // a frame counts only with exactly sixteen bits
  assign frame_ok = ss_rise & (st_q == OSSD_SHIFT) & addr_ok_q
                    & (cnt_q == FRAME_LAST + 5'h01);
  assign cmd      = rx_q[CMD_LSB +: CMD_W];

  // ---------------------------------------------------------------
  // command effects
  // ---------------------------------------------------------------
  // chip reset disables; only the soft reset command enables
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enabled_q <= 1'b0;
    end else if (frame_ok && cmd == OSSD_CMD_SRST) begin
      enabled_q <= 1'b1;
    end
  end

  // per-stage open-load diagnosis disable
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ol_dis_q <= '0;
    end else if (frame_ok && cmd == OSSD_CMD_SRST) begin
      ol_dis_q <= '0;
    end else if (frame_ok && cmd == OSSD_CMD_CFG) begin
      ol_dis_q <= rx_q[NSTAGE-1:0];
    end
  end

  logic flag_clr;
  assign flag_clr = frame_ok & (cmd == OSSD_CMD_CLEAR ||
                                cmd == OSSD_CMD_SRST);

  // ---------------------------------------------------------------
  // stages: drive, blanking, fault filters
  // ---------------------------------------------------------------
  logic [NSTAGE-1:0]      on_q;
  logic [NSTAGE*NFLT-1:0] cond;

  for (genvar i = 0; i < NSTAGE; i++) begin : g_stage
    logic [BW-1:0] blank_q;
    logic          blank_done;

    // inverting: low input turns on; off in reset, before soft
    // reset, and after a latched battery short
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        on_q[i] <= 1'b0;
      end else begin
        on_q[i] <= enabled_q & ~in_s[i]
                   & ~flag_q[i*NFLT+F_SCB];
      end
    end

    // blanking counter restarts on every switch-on
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        blank_q <= '0;
      end else if (!on_q[i]) begin
        blank_q <= '0;
      end else if (blank_q != BLANK_END) begin
        blank_q <= blank_q + BW'(1);
      end
    end
    assign blank_done = (blank_q == BLANK_END);

    // open/ground only while off, battery short only while on
    assign cond[i*NFLT+F_SCB] = on_q[i] & blank_done & scb_s[i];
    assign cond[i*NFLT+F_SCG] = ~on_q[i] & scg_s[i];
    assign cond[i*NFLT+F_OL]  = ~on_q[i] & ~ol_dis_q[i] & ol_s[i];

    // no diagnostic current when disabled or while driving
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        o_diag_cur_en[i] <= 1'b0;
      end else begin
        o_diag_cur_en[i] <= ~ol_dis_q[i] & ~on_q[i];
      end
    end

    assign o_battery_short_fault[i] = flag_q[i*NFLT+F_SCB];
    assign o_ground_short_fault[i]  = flag_q[i*NFLT+F_SCG];
    assign o_open_load_fault[i]     = flag_vis[i*NFLT+F_OL];
  end

  // glitch filters: condition must hold FILT_N cycles in a row
  for (genvar j = 0; j < NSTAGE*NFLT; j++) begin : g_filt
    logic [FW-1:0] fc_q;
    logic          hit;
    assign hit = cond[j] & (fc_q == FILT_END);

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        fc_q <= '0;
      end else if (!cond[j]) begin
        fc_q <= '0;
      end else if (fc_q != FILT_END) begin
        fc_q <= fc_q + FW'(1);
      end
    end

    // sticky flag; a new hit beats a clear in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        flag_q[j] <= 1'b0;
      end else begin
        flag_q[j] <= hit | (flag_q[j] & ~flag_clr);
      end
    end
  end

  // open-load indication suppressed while its diagnosis is off
  always_comb begin
    flag_vis = flag_q;
    for (int k = 0; k < NSTAGE; k++) begin
      flag_vis[k*NFLT+F_OL] = flag_q[k*NFLT+F_OL] & ~ol_dis_q[k];
    end
  end

  assign o_stage_output   = on_q;
  assign o_stages_enabled = enabled_q;
endmodule

/* File: logic/ossd_host.sv */
// Purpose: SPI master for the stage devices, mode 0, 16-bit frames
// Assumes: one request at a time, taken only while o_ready is high
// Notes:   after reset sends a soft reset to every device address
`timescale 1ns/100ps
module ossd_host
  import ossd_pkg::*;
#(
  parameter int HALF_N = ossd_pkg::HALF_CYC
) (
  // clock and reset
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_arst_n,
  // request
  input  wire logic                         i_req,
  input  wire logic [ossd_pkg::ADDR_W-1:0]  i_addr,
  input  wire logic [ossd_pkg::CMD_W-1:0]   i_cmd,
  input  wire logic [ossd_pkg::DATA_W-1:0]  i_data,
  // answer
  output logic                              o_ready,
  output logic                              o_done,
  output logic [ossd_pkg::FRAME_BITS-1:0]   o_rdata,
  output logic                              o_init_done,
  // serial link
  ossd_if.host                              spi
);
  import ossd_pkg::*;

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  // a shorter half period would run the link above its limit
  if (HALF_N < HALF_CYC) begin : g_bad_par
    $error("ossd_host: serial clock faster than the device allows");
  end

  localparam int HW = $clog2(HALF_N + 1);
  localparam logic [HW-1:0] HALF_END = HW'(HALF_N - 1);
  localparam logic [ADDR_W-1:0] ADDR_LAST = ADDR_W'(NDEV - 1);

  typedef enum logic [2:0] {
    OSSD_H_IDLE, OSSD_H_LEAD, OSSD_H_HI, OSSD_H_LO, OSSD_H_END,
    OSSD_H_GAP
  } ossd_hst_e;

  ossd_hst_e             st_q;
  logic [HW-1:0]         div_q;
  logic                  tick;
  logic [4:0]            bit_q;
  logic [FRAME_BITS-1:0] sh_q;
  logic [FRAME_BITS-1:0] rx_q;
  logic                  miso1_q, miso2_q;
  logic                  init_q;
  logic [ADDR_W-1:0]     init_addr_q;
  logic                  start;
  logic [FRAME_BITS-1:0] frame;

  // ---------------------------------------------------------------
  // data-in synchroniser and rate divider
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      miso1_q <= 1'b1;
      miso2_q <= 1'b1;
    end else begin
      miso1_q <= spi.miso_line;
      miso2_q <= miso1_q;
    end
  end

  // one tick per half serial period while a frame runs
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q <= '0;
    end else if (st_q == OSSD_H_IDLE || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + HW'(1);
    end
  end
  assign tick = (st_q != OSSD_H_IDLE) && (div_q == HALF_END);

  // ---------------------------------------------------------------
  // request selection: soft resets first, then user frames
  // ---------------------------------------------------------------
  assign o_ready     = (st_q == OSSD_H_IDLE) & init_q;
  assign o_init_done = init_q;
  assign start = (st_q == OSSD_H_IDLE) & (~init_q | i_req);
  // address in the top two bits of every frame
  assign frame = init_q ? {i_addr, i_cmd, i_data}
                        : {init_addr_q, OSSD_CMD_SRST, {DATA_W{1'b0}}};

  // soft reset sweep over all addresses after chip reset
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      init_q      <= 1'b0;
      init_addr_q <= '0;
    end else if (!init_q && st_q == OSSD_H_GAP && tick) begin
      init_addr_q <= init_addr_q + ADDR_W'(1);
      init_q      <= (init_addr_q == ADDR_LAST);
    end
  end

  // ---------------------------------------------------------------
  // frame sequencer, master owns clock and select
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= OSSD_H_IDLE;
    end else begin
      case (st_q)
        OSSD_H_IDLE: if (start) st_q <= OSSD_H_LEAD;
        OSSD_H_LEAD: if (tick) st_q <= OSSD_H_HI;
        OSSD_H_HI:   if (tick) st_q <= (bit_q == FRAME_LAST) ?
                                       OSSD_H_END : OSSD_H_LO;
        OSSD_H_LO:   if (tick) st_q <= OSSD_H_HI;
        OSSD_H_END:  if (tick) st_q <= OSSD_H_GAP;
        OSSD_H_GAP:  if (tick) st_q <= OSSD_H_IDLE;
        default:     st_q <= OSSD_H_IDLE;
      endcase
    end
  end

  // mode 0: clock idles low, sample on rise, shift on fall
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      spi.sck  <= 1'b0;
      spi.ss_n <= 1'b1;
      sh_q     <= '0;
      rx_q     <= '0;
      bit_q    <= 5'h00;
    end else if (start) begin
      spi.ss_n <= 1'b0;
      sh_q     <= frame;
      bit_q    <= 5'h00;
    end else if (tick) begin
      case (st_q)
        OSSD_H_LEAD, OSSD_H_LO: begin
          spi.sck <= 1'b1;
          rx_q    <= {rx_q[FRAME_BITS-2:0], miso2_q};
        end
        OSSD_H_HI: begin
          spi.sck <= 1'b0;
          bit_q   <= bit_q + 5'h01;
          sh_q    <= {sh_q[FRAME_BITS-2:0], 1'b0};
        end
        OSSD_H_END: spi.ss_n <= 1'b1;
        default: ;
      endcase
    end
  end
  assign spi.mosi = sh_q[FRAME_BITS-1];

  // reply word and completion pulse at select release
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
      o_done  <= 1'b0;
    end else begin
      o_done <= tick & (st_q == OSSD_H_END) & init_q;
      if (tick && st_q == OSSD_H_END) begin
        o_rdata <= rx_q;
      end
    end
  end
endmodule

/* File: logic/ossd_if.sv */
// Purpose: SPI carrier between host controller and the stage device
// Assumes: one device end and one host end per instance
// Notes:   a released data-out line reads high on the wire
`timescale 1ns/100ps
interface ossd_if;
  logic sck;
  logic ss_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // wire level of the shared data-out line, idle high when released
  assign miso_line = miso_oe ? miso : 1'b1;

  modport dev  (input sck, ss_n, mosi, output miso, miso_oe);
  modport host (output sck, ss_n, mosi, input miso_line);
endinterface

/* File: logic/ossd_pkg.sv */
// Purpose: shared constants for the output stage diagnostics link
// Assumes: 100 MHz system clock, 16-bit SPI mode 0 frames, MSB first
// Notes:   frame = addr(2) | cmd(2) | data(12); reply = status word
package ossd_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ   = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLANK_TIME_NS = 10_000;  // switch-on blanking time
  localparam int FILT_TIME_NS  = 5_000;   // fault glitch filter time
  localparam int SPI_MAX_BAUD  = 2_000_000;
  // least times round up
  localparam int BLANK_CYC = (BLANK_TIME_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int FILT_CYC  = (FILT_TIME_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  // half serial clock period, rounded up so the rate never exceeds max
  localparam int HALF_CYC  = (CLK_FREQ_HZ + 2 * SPI_MAX_BAUD - 1)
                             / (2 * SPI_MAX_BAUD);

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int NSTAGE     = 2;
  localparam int FRAME_BITS = 16;
  localparam int ADDR_W     = 2;
  localparam int CMD_W      = 2;
  localparam int DATA_W     = 12;
  localparam int ADDR_LSB   = 14;
  localparam int CMD_LSB    = 12;
  localparam int NDEV       = 4;
  localparam logic [4:0] FRAME_LAST = 5'h0f;

  typedef enum logic [CMD_W-1:0] {
    OSSD_CMD_STATUS = 2'h0,   // read status only
    OSSD_CMD_SRST   = 2'h1,   // soft reset, enables the stages
    OSSD_CMD_CFG    = 2'h2,   // data[1:0] = open-load diag disable
    OSSD_CMD_CLEAR  = 2'h3    // read status, then clear fault flags
  } ossd_cmd_e;

  // ---------------------------------------------------------------
  // status word and fault vector
  // ---------------------------------------------------------------
  localparam int ST_EN_BIT  = 13;
  localparam int ST_OLD_LSB = 11;
  localparam int ST_FLT_LSB = 0;
  localparam int NFLT       = 3;   // faults per stage
  localparam int F_OL       = 0;
  localparam int F_SCG      = 1;
  localparam int F_SCB      = 2;
endpackage

/* File: test/ossd_link_asserts.sv */
// Purpose: link timing checks between host end and device end
// Assumes: one host and one device on the watched link
// Notes:   sees only the interface wires, clock and reset
`timescale 1ns/100ps
module ossd_link_asserts (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // link wires
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  logic [5:0] rise_q;
  // serial clock rises of the current frame; kept after select release
  // because data out lags the select by the device's two flops
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n)
      rise_q <= 6'h00;
    else if ($fell(ss_n))
      rise_q <= 6'h00;
    else if (!ss_n && $rose(sck))
      rise_q <= rise_q + 6'h01;
  end
  sequence s_open; $fell(ss_n) ##1 !ss_n [*8]; endsequence
  sequence s_idle; ss_n [*4]; endsequence
  property p_frame_len; s_open |-> ##[700:1000] ss_n; endproperty
  property p_rises; $rose(ss_n) |-> rise_q == 6'h10; endproperty
  property p_sck_idle; ss_n |-> !sck; endproperty
  property p_oe_sel; s_idle |-> !miso_oe; endproperty
  property p_oe_rst; $rose(i_arst_n) |-> !miso_oe; endproperty
  property p_addr_gate; miso_oe |-> rise_q >= 6'h02; endproperty
  property p_mosi_hold; $rose(sck) |-> $stable(mosi); endproperty
  property p_sck_high; $rose(sck) |-> sck [*8]; endproperty
  property p_sck_low; $fell(sck) && !ss_n |-> !sck [*8]; endproperty
  // miso only moves after a fall, so a long high phase sees it still
  property p_miso_hold;
    miso_oe && $past(miso_oe) && sck && $past(sck, 4) |-> $stable(miso);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame select length out of range");
  a_rises: assert property (p_rises)
    else $error("frame closed without sixteen clock rises");
  a_sck_idle: assert property (p_sck_idle)
    else $error("serial clock high while deselected");
  a_oe_sel: assert property (p_oe_sel)
    else $error("data out driven while deselected");
  a_oe_rst: assert property (p_oe_rst)
    else $error("data out driven right after reset");
  a_addr_gate: assert property (p_addr_gate)
    else $error("data out driven before address bits");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("host data moved at clock rise");
  a_sck_high: assert property (p_sck_high)
    else $error("serial clock high phase too short");
  a_sck_low: assert property (p_sck_low)
    else $error("serial clock low phase too short");
  a_miso_hold: assert property (p_miso_hold)
    else $error("device data moved during high phase");
  property p_line_idle; s_idle |-> miso_line; endproperty
  a_line_idle: assert property (p_line_idle)
    else $error("data line not released while deselected");
endmodule

/* File: test/tb_output_stage_diag_spi.sv */
// Purpose: host end and device end joined, checked against a model
// Assumes: device at address 0, blanking 8 and filter 4 cycles
// Notes:   comparator inputs are driven by the bench as fault sources
`timescale 1ns/100ps
module tb_output_stage_diag_spi;
  import ossd_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, req = 1'b0;
  logic [1:0]  addr = 2'h0, cmd = 2'h0, stg_in = 2'h0;
  logic [1:0]  battery_short_fault = 2'h0, ground_short_fault = 2'h0, ol = 2'h0;
  logic [11:0] data = 12'h000;
  logic        ready, done, init_done, en;
  logic [15:0] rdata;
  logic [1:0]  stg_out, cur_en, f_scb, f_scg, f_ol;
  int          bad_count = 0, n_checks = 0, seed, k, m_en, m_dis, m_flt;
  ossd_if lnk ();
  ossd_host u_ossd_host (.i_ref_clk(clk), .i_arst_n(arst_n), .i_req(req),
    .i_addr(addr), .i_cmd(cmd), .i_data(data), .o_ready(ready),
    .o_done(done), .o_rdata(rdata), .o_init_done(init_done), .spi(lnk));
  ossd_dev #(.DEV_ADDR(2'h0), .BLANK_N(8), .FILT_N(4)) u_ossd_dev (
    .i_ref_clk(clk), .i_arst_n(arst_n), .i_stage_input(stg_in),
    .i_scb_cmp(battery_short_fault), .i_scg_cmp(ground_short_fault), .i_ol_cmp(ol),
    .o_stage_output(stg_out), .o_diag_cur_en(cur_en),
    .o_battery_short_fault(f_scb), .o_ground_short_fault(f_scg),
    .o_open_load_fault(f_ol), .o_stages_enabled(en), .spi(lnk));
  ossd_link_asserts u_chk (.i_ref_clk(clk), .i_arst_n(arst_n),
    .sck(lnk.sck), .ss_n(lnk.ss_n), .mosi(lnk.mosi), .miso(lnk.miso),
    .miso_oe(lnk.miso_oe), .miso_line(lnk.miso_line));
  // --------------------------------------------------------------
  // clock, helpers and model
  // --------------------------------------------------------------
  always #5 clk = ~clk;
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_pin(string nm, logic [1:0] e, logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_word(string nm, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // one frame; bounded waits so a stuck host cannot hang the run
  task automatic xfer(logic [1:0] a, logic [1:0] c, logic [11:0] d);
    int t;
    t = 0;
    while (ready !== 1'b1 && t < 3000) begin cyc(1); t++; end
    if (t == 3000) bad_count++;
    addr = a; cmd = c; data = d; req = 1'b1;
    cyc(1);
    req = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 3000) begin cyc(1); t++; end
    if (t == 3000) bad_count++;
  endtask
  // soft reset sweep after chip reset, bounded like a transfer
  task automatic wait_init();
    int t;
    t = 0;
    while (init_done !== 1'b1 && t < 6000) begin cyc(1); t++; end
    if (t == 6000) bad_count++;
    m_en = 1;
    cyc(8);
  endtask
  // address slot reads high: data out is released there
  function automatic logic [15:0] m_word();
    logic [15:0] w;
    w = 16'hc000 | 16'(m_en << 13) | 16'(m_dis << 11) | 16'(m_flt);
    for (int i = 0; i < 2; i++) if (m_dis[i]) w[i*3] = 1'b0;
    return w;
  endfunction
  function automatic logic [1:0] m_pin(int f);
    logic [1:0] p;
    p = {m_flt[3+f], m_flt[f]};
    if (f == F_OL) p = p & ~2'(m_dis);
    return p;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard, far beyond the expected run of about 15k cycles
  initial begin
    #600000;
    bad_count++;
    summarize();
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 32'h0456; m_en = 0; m_dis = 0; m_flt = 0;
    cyc(5);
    chk_pin("out_rst", 2'h0, stg_out);
    arst_n = 1'b1;
    cyc(10);
    chk_pin("out_pre", 2'h0, stg_out);
    chk_pin("en_pre", 2'h0, {1'b0, en});
    wait_init();
    chk_pin("out_on", 2'h3, stg_out);
    chk_pin("en", 2'(m_en), {1'b0, en});
    for (k = 0; k < 6; k++) begin
      stg_in = 2'($random(seed));
      cyc(6);
      chk_pin("follow", ~stg_in, stg_out);
    end
    stg_in = 2'h3;
    cyc(6);
    chk_pin("float", 2'h0, stg_out);
    $display("stage follow test done");
    xfer(2'h0, OSSD_CMD_STATUS, 12'($random(seed)));
    chk_word("status", m_word(), rdata);
    for (k = 1; k < 4; k++) begin
      xfer(2'(k), OSSD_CMD_CFG, 12'h003);
      chk_word("other", 16'hffff, rdata);
    end
    xfer(2'h0, OSSD_CMD_STATUS, 12'h000);
    chk_word("status2", m_word(), rdata);
    $display("addressing test done");
    ol = 2'h2; cyc(2); ol = 2'h0; cyc(10);
    chk_pin("glitch", 2'h0, f_ol);
    ol = 2'h1; ground_short_fault = 2'h2; battery_short_fault = 2'h3; cyc(20);
    ol = 2'h0; ground_short_fault = 2'h0; battery_short_fault = 2'h0; cyc(4);
    m_flt = (1 << F_OL) | (1 << (3 + F_SCG));
    chk_pin("ol", m_pin(F_OL), f_ol);
    chk_pin("scg", m_pin(F_SCG), f_scg);
    chk_pin("scb_idle", m_pin(F_SCB), f_scb);
    xfer(2'h0, OSSD_CMD_CFG, 12'h001);
    m_dis = 1;
    cyc(8);
    chk_pin("ol_mask", m_pin(F_OL), f_ol);
    chk_pin("cur", 2'h2, cur_en);
    xfer(2'h0, OSSD_CMD_CLEAR, 12'h000);
    chk_word("clear", m_word(), rdata);
    m_flt = 0;
    cyc(8);
    chk_pin("cleared", m_pin(F_SCG), f_scg);
    $display("idle fault test done");
    stg_in = 2'h2; battery_short_fault = 2'h3; cyc(40);
    m_flt = 1 << F_SCB;
    chk_pin("scb", m_pin(F_SCB), f_scb);
    chk_pin("scb_cut", 2'h0, stg_out);
    battery_short_fault = 2'h0;
    xfer(2'h0, OSSD_CMD_SRST, 12'h000);
    m_flt = 0; m_dis = 0;
    cyc(8);
    chk_pin("srst", 2'h1, stg_out);
    xfer(2'h0, OSSD_CMD_STATUS, 12'h000);
    chk_word("status3", m_word(), rdata);
    $display("battery short test done");
    arst_n = 1'b0;
    m_en = 0;
    cyc(2);
    chk_pin("out_rst2", 2'h0, stg_out);
    chk_pin("en_rst2", 2'(m_en), {1'b0, en});
    arst_n = 1'b1;
    cyc(10);
    chk_pin("out_pre2", 2'h0, stg_out);
    wait_init();
    chk_pin("out_on2", 2'h1, stg_out);
    $display("mid-run reset test done");
    summarize();
  end
endmodule
